//--- plsl_defs.svh
`ifndef PLSL_DEFS_SVH
`define PLSL_DEFS_SVH

// ----------------------------------------------------------------
// Register byte addresses (printed offsets are indices)
// ----------------------------------------------------------------
`define PLSL_IDX_SELFTEST 8'h16
`define PLSL_IDX_STATUS 8'h17
`define PLSL_IDX_LAMPMAP 8'h18
`define PLSL_ADDR_SELFTEST 12'h058
`define PLSL_ADDR_STATUS 12'h05C
`define PLSL_ADDR_LAMPMAP 12'h060

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define PLSL_LOOP_MSB 1
`define PLSL_ST_SYNC 11
`define PLSL_ST_DROP 10
`define PLSL_ST_GEN 9
`define PLSL_ST_MSCR 8
`define PLSL_ST_SSCR 7
`define PLSL_ST_PWR 6
`define PLSL_AUX_LSB 12
`define PLSL_L2_LSB 8
`define PLSL_L1_LSB 4
`define PLSL_L0_LSB 0

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define PLSL_LOOP_RST 2'h0
`define PLSL_MAP_RST 16'h6150

// ----------------------------------------------------------------
// Lamp source codes
// ----------------------------------------------------------------
`define PLSL_SRC_LINK 4'h0
`define PLSL_SRC_ACT 4'h1
`define PLSL_SRC_TXACT 4'h2
`define PLSL_SRC_RXACT 4'h3
`define PLSL_SRC_COL 4'h4
`define PLSL_SRC_L1000 4'h5
`define PLSL_SRC_L100 4'h6
`define PLSL_SRC_L10 4'h7
`define PLSL_SRC_L10_100 4'h8
`define PLSL_SRC_L100_1000 4'h9
`define PLSL_SRC_FDX 4'hA
`define PLSL_SRC_BLINK 4'hB
`define PLSL_SRC_ERR 4'hD
`define PLSL_SRC_RXERR 4'hE

// ----------------------------------------------------------------
// Blink timing
// ----------------------------------------------------------------
`define PLSL_BLINK_MS 50
`define PLSL_CLK_MHZ 200
`define PLSL_BLINK_CYC (`PLSL_BLINK_MS * 1000 * `PLSL_CLK_MHZ)

`endif

//--- plsl_pkg.sv
package plsl_pkg;

  typedef enum logic [1:0] {
    plsl_loop_off,
    plsl_loop_pre_scr,
    plsl_loop_post_scr,
    plsl_loop_post_enc
  } plsl_loop_e;

  typedef enum logic [1:0] {
    plsl_speed_10,
    plsl_speed_100,
    plsl_speed_1000
  } plsl_speed_e;

endpackage

//--- plsl_tb_top.sv
`timescale 1ns/1ps
module plsl_tb_top;
  logic ref_clk, rst_b, psel, penable, pwrite, pready, pslverr, aux, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [8:0] ln;
  logic [4:0] st;
  logic [1:0] sel;
  logic [3:0] lp;
  logic [2:0] lamp;
  logic [8:0] pats [4] = '{9'h0D3, 9'h06C, 9'h160, 9'h080};
  int fail_count, n_tests, ones;

  plsl_top #(.BLINK_CYCLES(8)) u_dut (.ref_clk(ref_clk), .rst_b(rst_b), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .link_speed(ln[8:7]), .link_up(ln[6]), .full_duplex(ln[5]), .tx_active(ln[4]), .rx_active(ln[3]),
    .tx_error(ln[2]), .rx_error(ln[1]), .collision(ln[0]), .prbs_locked(st[4]), .frame_gen_running(st[3]),
    .master_legacy_scr(st[2]), .slave_legacy_scr(st[1]), .core_awake(st[0]), .pcs_loop_point_select(sel),
    .loop_pre_scrambler(lp[0]), .loop_post_scrambler(lp[1]), .loop_post_encoder(lp[2]),
    .loop_pre_gig_dsp(lp[3]), .lamp_output(lamp), .aux_lamp_output(aux));

  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n == 20) fail_count++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
  endtask

  task automatic rchk(input string nm, input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(nm, rd, exp);
  endtask

  function automatic logic lamp_exp(input logic [3:0] c);
    case (c)
      4'h0: return ln[6];
      4'h1: return ln[4] | ln[3];
      4'h2: return ln[4];
      4'h3: return ln[3];
      4'h4: return ln[0];
      4'h5: return ln[6] && ln[8:7] == 2'h2;
      4'h6: return ln[6] && ln[8:7] == 2'h1;
      4'h7: return ln[6] && ln[8:7] == 2'h0;
      4'h8: return ln[6] && ln[8:7] != 2'h2;
      4'h9: return ln[6] && ln[8:7] != 2'h0;
      4'hA: return ln[5];
      4'hB: return ln[6];
      4'hD: return ln[2] | ln[1];
      4'hE: return ln[1];
      default: return 1'b0;
    endcase
  endfunction

  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  initial begin
    tick(20000);
    fail_count++;
    end_sim();
  end

  initial begin
    rst_b = 1'b0;
    {psel, penable, pwrite} = 3'h0;
    paddr = 12'h000;
    pwdata = 32'h0;
    ln = 9'h000;
    st = 5'h00;
    tick(4);
    rst_b <= 1'b1;
    tick(1);
    rchk("status reset", 12'h05C, 32'h0);
    rchk("map reset", 12'h060, 32'h6150);
    apb(1'b1, 12'h060, 32'hFFFF1234);
    rchk("map write", 12'h060, 32'h1234);
    apb(1'b1, 12'h05C, 32'hFFFFFFFF);
    rchk("status write", 12'h05C, 32'h0);
    apb(1'b1, 12'h040, 32'hFFFFFFFF);
    chk("unmapped error", {31'h0, err}, 32'h1);
    rchk("unmapped read", 12'h040, 32'h0);
    st <= 5'h1D;
    tick(6);
    rchk("status on", 12'h05C, 32'hB40);
    st <= 5'h02;
    tick(6);
    rchk("lock lost", 12'h05C, 32'h480);
    rchk("read clear", 12'h05C, 32'h080);
    for (int s = 0; s < 3; s++) begin
      ln <= {s[1:0], 7'h00};
      for (int k = 0; k < 4; k++) begin
        apb(1'b1, 12'h058, 32'(k));
        tick(4);
        chk("loop select", sel, 32'(k));
        chk("loop out", lp, {s == 2 && k[0], s == 1 && k == 3, s == 1 && k == 2, s == 1 && k == 1});
      end
      apb(1'b1, 12'h058, 32'h0);
    end
    for (int p = 0; p < 4; p++) begin
      ln <= pats[p];
      tick(6);
      for (int c = 0; c < 16; c++) begin
        if (c != 11 || !(ln[4] | ln[3])) begin
          apb(1'b1, 12'h060, {16'h0, {4{c[3:0]}}});
          tick(3);
          chk("lamp", {aux, lamp}, {4{lamp_exp(c[3:0])}});
        end
      end
    end
    ln <= 9'h0D0;
    apb(1'b1, 12'h060, 32'hBBBB);
    tick(6);
    ones = 0;
    for (int i = 0; i < 32; i++) begin
      tick(1);
      ones += int'(lamp[0] === 1'b1);
    end
    chk("blink", 32'(ones > 0 && ones < 32), 32'h1);
    end_sim();
  end
endmodule // plsl_tb_top

//--- plsl_top.sv
// How it works
// - 100BASE-TX with selector 11 loops after the line encoder.
// - 100BASE-TX with selector 10 loops after scrambler, before encoder.
// - 100BASE-TX with selector 01 loops before the scrambler.
// - Gigabit: selector low bit one loops before signal processing.
// - Status bit 11 shows checker synchronised.
// - Status bit 10 latches sync loss until a status read clears it.
// - Status bit 9 shows packet generator busy.
// - Status bit 8 shows gigabit master legacy scramble.
// - Status bit 7 shows gigabit slave legacy scramble.
// - Status bit 6 shows core in normal power.
// - Reserved status bits read zero, ignore writes, fields reset zero.
// - Lamp map holds four 4-bit selectors at 15:12, 11:8, 7:4, 3:0.
// - Selectors reset to 0110, 0001, 0101, 0000 and are writable.
// - Codes 0000 any link, 0111 10M link, 0110 100M link.
// - Codes 1000 10/100 link, 1001 100/1000 link, 0101 gigabit.
// - Codes 0001 any activity, 0010 transmit, 0011 receive.
// - Code 1010 full duplex; 1011 link with blink on activity.
// - Code 1101 any error, 1110 receive error; 1100, 1111 reserved.
`include "plsl_defs.svh"
`timescale 1ns/1ps

module plsl_top
  import plsl_pkg::*;
#(
  parameter int unsigned BLINK_CYCLES = `PLSL_BLINK_CYC
) (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [1:0] link_speed,
  input wire logic link_up,
  input wire logic full_duplex,
  input wire logic tx_active,
  input wire logic rx_active,
  input wire logic tx_error,
  input wire logic rx_error,
  input wire logic collision,
  input wire logic prbs_locked,
  input wire logic frame_gen_running,
  input wire logic master_legacy_scr,
  input wire logic slave_legacy_scr,
  input wire logic core_awake,
  output logic [1:0] pcs_loop_point_select,
  output logic loop_pre_scrambler,
  output logic loop_post_scrambler,
  output logic loop_post_encoder,
  output logic loop_pre_gig_dsp,
  output logic [2:0] lamp_output,
  output logic aux_lamp_output
);

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  localparam int NSYNC = 15;
  logic [NSYNC-1:0] sync_a;
  logic [NSYNC-1:0] sync_b;
  wire logic [NSYNC-1:0] raw_in = {link_speed, link_up, full_duplex, tx_active, rx_active, tx_error,
                                   rx_error, collision, prbs_locked, frame_gen_running,
                                   master_legacy_scr, slave_legacy_scr, core_awake, 1'b0};

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      sync_a <= '0;
      sync_b <= '0;
    end else begin
      sync_a <= raw_in;
      sync_b <= sync_a;
    end
  end

  plsl_speed_e speed_s;
  logic link_s, fdx_s, txa_s, rxa_s, txe_s, rxe_s, col_s;
  logic prbs_sync_flag, frame_generator_active, gig_legacy_scramble_flag;
  logic slave_scr_s, core_normal_power_flag;
  always_comb begin
    speed_s = plsl_speed_e'(sync_b[14:13]);
    link_s = sync_b[12];
    fdx_s = sync_b[11];
    txa_s = sync_b[10];
    rxa_s = sync_b[9];
    txe_s = sync_b[8];
    rxe_s = sync_b[7];
    col_s = sync_b[6];
    prbs_sync_flag = sync_b[5];
    frame_generator_active = sync_b[4];
    gig_legacy_scramble_flag = sync_b[3];
    slave_scr_s = sync_b[2];
    core_normal_power_flag = sync_b[1];
  end

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  wire logic access = psel && penable;
  wire logic wr = access && pwrite;
  wire logic rd = access && !pwrite;
  wire logic hit_st = (paddr == `PLSL_ADDR_SELFTEST);
  wire logic hit_ss = (paddr == `PLSL_ADDR_STATUS);
  wire logic hit_lm = (paddr == `PLSL_ADDR_LAMPMAP);

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [15:0] indicator_source_map;
  logic prbs_sync_dropped;
  logic sync_prev;

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      pcs_loop_point_select <= `PLSL_LOOP_RST;
    end else if (wr && hit_st) begin
      pcs_loop_point_select <= pwdata[`PLSL_LOOP_MSB:0];
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      indicator_source_map <= `PLSL_MAP_RST;
    end else if (wr && hit_lm) begin
      indicator_source_map <= pwdata[15:0];
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      sync_prev <= 1'b0;
      prbs_sync_dropped <= 1'b0;
    end else begin
      sync_prev <= prbs_sync_flag;
      if (sync_prev && !prbs_sync_flag) begin
        prbs_sync_dropped <= 1'b1;
      end else if (rd && hit_ss) begin
        prbs_sync_dropped <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Read data and response
  // ----------------------------------------------------------------
  logic [15:0] status_word;
  logic [31:0] next_prdata;
  always_comb begin
    status_word = '0;
    status_word[`PLSL_ST_SYNC] = prbs_sync_flag;
    status_word[`PLSL_ST_DROP] = prbs_sync_dropped;
    status_word[`PLSL_ST_GEN] = frame_generator_active;
    status_word[`PLSL_ST_MSCR] = gig_legacy_scramble_flag;
    status_word[`PLSL_ST_SSCR] = slave_scr_s;
    status_word[`PLSL_ST_PWR] = core_normal_power_flag;
    next_prdata = '0;
    if (hit_st) begin
      next_prdata = {30'h0, pcs_loop_point_select};
    end else if (hit_ss) begin
      next_prdata = {16'h0, status_word};
    end else if (hit_lm) begin
      next_prdata = {16'h0, indicator_source_map};
    end
  end

  logic next_pready;
  assign next_pready = psel && !penable;

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= '0;
    end else begin
      pready <= next_pready;
      pslverr <= next_pready && !(hit_st || hit_ss || hit_lm);
      prdata <= (next_pready && !pwrite) ? next_prdata : 32'h0;
    end
  end

  // ----------------------------------------------------------------
  // Loopback point decode
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      loop_pre_scrambler <= 1'b0;
      loop_post_scrambler <= 1'b0;
      loop_post_encoder <= 1'b0;
      loop_pre_gig_dsp <= 1'b0;
    end else begin
      loop_pre_scrambler <= (speed_s == plsl_speed_100) &&
                            (plsl_loop_e'(pcs_loop_point_select) == plsl_loop_pre_scr);
      loop_post_scrambler <= (speed_s == plsl_speed_100) &&
                             (plsl_loop_e'(pcs_loop_point_select) == plsl_loop_post_scr);
      loop_post_encoder <= (speed_s == plsl_speed_100) &&
                           (plsl_loop_e'(pcs_loop_point_select) == plsl_loop_post_enc);
      loop_pre_gig_dsp <= (speed_s == plsl_speed_1000) && pcs_loop_point_select[0];
    end
  end

  // ----------------------------------------------------------------
  // Blink timer
  // ----------------------------------------------------------------
  logic [31:0] blink_cnt;
  logic blink_phase;
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      blink_cnt <= '0;
      blink_phase <= 1'b0;
    end else if (blink_cnt >= BLINK_CYCLES - 1) begin
      blink_cnt <= '0;
      blink_phase <= !blink_phase;
    end else begin
      blink_cnt <= blink_cnt + 32'h1;
    end
  end

  // ----------------------------------------------------------------
  // Lamp source selection
  // ----------------------------------------------------------------
  function automatic logic lamp_pick(input logic [3:0] code);
    logic v;
    v = 1'b0;
    case (code)
      `PLSL_SRC_LINK: v = link_s;
      `PLSL_SRC_L10: v = link_s && (speed_s == plsl_speed_10);
      `PLSL_SRC_L100: v = link_s && (speed_s == plsl_speed_100);
      `PLSL_SRC_L10_100: v = link_s && (speed_s != plsl_speed_1000);
      `PLSL_SRC_L100_1000: v = link_s && (speed_s != plsl_speed_10);
      `PLSL_SRC_L1000: v = link_s && (speed_s == plsl_speed_1000);
      `PLSL_SRC_ACT: v = txa_s || rxa_s;
      `PLSL_SRC_TXACT: v = txa_s;
      `PLSL_SRC_RXACT: v = rxa_s;
      `PLSL_SRC_FDX: v = fdx_s;
      `PLSL_SRC_BLINK: v = link_s && !((txa_s || rxa_s) && blink_phase);
      `PLSL_SRC_ERR: v = txe_s || rxe_s;
      `PLSL_SRC_RXERR: v = rxe_s;
      `PLSL_SRC_COL: v = col_s;
      default: v = 1'b0;
    endcase
    return v;
  endfunction

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_lamp
      always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
          lamp_output[gi] <= 1'b0;
        end else begin
          lamp_output[gi] <= lamp_pick(indicator_source_map[gi*4 +: 4]);
        end
      end
    end
  endgenerate

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      aux_lamp_output <= 1'b0;
    end else begin
      aux_lamp_output <= lamp_pick(indicator_source_map[`PLSL_AUX_LSB +: 4]);
    end
  end

endmodule // plsl_top

//--- plsl_top_asserts.sv
`timescale 1ns/1ps
module plsl_top_asserts (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [1:0] link_speed,
  input wire logic prbs_locked,
  input wire logic frame_gen_running,
  input wire logic master_legacy_scr,
  input wire logic slave_legacy_scr,
  input wire logic core_awake,
  input wire logic [1:0] pcs_loop_point_select,
  input wire logic loop_pre_scrambler,
  input wire logic loop_post_scrambler,
  input wire logic loop_post_encoder,
  input wire logic loop_pre_gig_dsp
);
  logic [6:0] ins;
  logic [6:0] ins_q;
  logic [2:0] quiet;
  logic calm, st_rd, s100, s1g;
  assign ins = {link_speed, prbs_locked, frame_gen_running, master_legacy_scr, slave_legacy_scr, core_awake};
  assign calm = quiet >= 3'h5;
  assign st_rd = pready && !pwrite && paddr == 12'h05C;
  assign s100 = link_speed == 2'h1;
  assign s1g = link_speed == 2'h2;
  // Counts cycles since the slow status inputs last moved, holding at 5.
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      ins_q <= 7'h00;
      quiet <= 3'h0;
    end else begin
      ins_q <= ins;
      quiet <= (ins != ins_q) ? 3'h0 : (calm ? quiet : quiet + 3'h1);
    end
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  AST_LOOP_ENC: assert property (calm |-> loop_post_encoder == (s100 && $past(pcs_loop_point_select) == 2'h3))
    else $error("loop after encoder wrong");
  AST_LOOP_SCR: assert property (calm |-> loop_post_scrambler == (s100 && $past(pcs_loop_point_select) == 2'h2))
    else $error("loop after scrambler wrong");
  AST_LOOP_PRE: assert property (calm |-> loop_pre_scrambler == (s100 && $past(pcs_loop_point_select) == 2'h1))
    else $error("loop before scrambler wrong");
  AST_LOOP_GIG: assert property (calm |-> loop_pre_gig_dsp == (s1g && $past(pcs_loop_point_select[0])))
    else $error("gigabit loop wrong");
  AST_ST_SYNC: assert property (st_rd && calm |-> prdata[11] == prbs_locked)
    else $error("sync bit wrong");
  AST_ST_GEN: assert property (st_rd && calm |-> prdata[9] == frame_gen_running)
    else $error("generator bit wrong");
  AST_ST_SCR: assert property (st_rd && calm |-> prdata[8:7] == {master_legacy_scr, slave_legacy_scr})
    else $error("scramble bits wrong");
  AST_ST_PWR: assert property (st_rd && calm |-> prdata[6] == core_awake)
    else $error("power bit wrong");
  AST_ST_RSVD: assert property (st_rd |-> prdata[31:12] == 20'h00000 && prdata[5:0] == 6'h00)
    else $error("reserved status bits set");
  AST_ONE_WAIT: assert property (psel && !penable |=> pready ##1 !pready)
    else $error("ready not one cycle after setup");
  cover property (st_rd && prdata[10]);
  cover property (loop_post_encoder);
  cover property (pready && pslverr);
endmodule // plsl_top_asserts

bind plsl_top plsl_top_asserts u_asrt (.ref_clk(ref_clk), .rst_b(rst_b), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr), .link_speed(link_speed),
  .prbs_locked(prbs_locked), .frame_gen_running(frame_gen_running), .master_legacy_scr(master_legacy_scr),
  .slave_legacy_scr(slave_legacy_scr), .core_awake(core_awake), .pcs_loop_point_select(pcs_loop_point_select),
  .loop_pre_scrambler(loop_pre_scrambler), .loop_post_scrambler(loop_post_scrambler),
  .loop_post_encoder(loop_post_encoder), .loop_pre_gig_dsp(loop_pre_gig_dsp));
